// >>> src/rf_frontend_control.sv
// receiver, oscillator and synthesizer control with apb register access
// ----------------------------------------
// ----------------------------------------
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module rf_frontend_control
#(
	parameter int unsigned CLKS_PER_MS = rf_frontend_pkg::CLKS_PER_MS
)
(
	input  wire logic        CLK_IN,
	input  wire logic        ARST_N_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	input  wire logic        RX_REQUEST_IN,
	input  wire logic        OSC_REQUEST_IN,
	input  wire logic        BATTERY_SENSE_IN,
	input  wire logic        DECODER_CLOCK_IN,
	output logic             RECEIVER_ENABLE_OUT,
	output logic             OSCILLATOR_ENABLE_OUT,
	output logic             RX_SETTLED_OUT,
	output logic             OSC_SETTLED_OUT,
	output logic             INT_OUT,
	output logic             SYNTH_SERIAL_DATA_OUT,
	output logic             SYNTH_SERIAL_CLOCK_OUT,
	output logic             SYNTH_LATCH_STROBE_OUT
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic        mon_rxe_ff;
	logic        cont_en_ff;
	logic        dec_on_ff;
	logic        synth_sel_ff;
	logic [1:0]  rate_ff;
	logic [1:0]  rx_est_ff;
	logic [1:0]  osc_est_ff;
	logic [23:0] block1_ff;
	logic [23:0] block2_ff;
	logic        bat_s1_ff;
	logic        bat_s2_ff;
	logic        dck_s1_ff;
	logic        dck_s2_ff;
	logic        dck_s3_ff;
	logic        bat_ff;
	logic        dec_on_prev_ff;
	logic        start_ff;
	logic [31:0] rx_cnt_ff;
	logic [31:0] osc_cnt_ff;
	logic        first_ff;

	logic        nxt_rxe;
	logic        nxt_roe;
	logic        rxe_fall;
	logic        mon_bit;
	logic        irq_set;
	logic        setup;
	logic        access_done;
	logic        rd_status;
	logic        wr_hit;
	logic        addr_ok;
	logic        dck_tick;
	logic        synth_busy;
	logic [6:0]  pause_len;
	logic [31:0] rd_word;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// establishment time for a select code, in clock cycles
	function automatic logic [31:0] est_cycles(input logic [1:0] sel, input logic is_osc);
		int unsigned ms;
		ms = 0;
		case (sel)
			2'h0:    ms = is_osc ? rf_frontend_pkg::OSC_EST_MS_0 : rf_frontend_pkg::RX_EST_MS_0;
			2'h1:    ms = is_osc ? rf_frontend_pkg::OSC_EST_MS_1 : rf_frontend_pkg::RX_EST_MS_1;
			2'h2:    ms = is_osc ? rf_frontend_pkg::OSC_EST_MS_2 : rf_frontend_pkg::RX_EST_MS_2;
			default: ms = is_osc ? rf_frontend_pkg::OSC_EST_MS_3 : rf_frontend_pkg::RX_EST_MS_3;
		endcase
		return 32'(ms * CLKS_PER_MS);
	endfunction

	function automatic logic is_reg(input logic [7:0] a);
		return a == rf_frontend_pkg::CTRL_OFS || a == rf_frontend_pkg::STATUS_OFS ||
			a == rf_frontend_pkg::CONFIG_OFS || a == rf_frontend_pkg::BLOCK1_OFS ||
			a == rf_frontend_pkg::BLOCK2_OFS;
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			bat_s1_ff <= 1'b0;
			bat_s2_ff <= 1'b0;
			dck_s1_ff <= 1'b0;
			dck_s2_ff <= 1'b0;
			dck_s3_ff <= 1'b0;
		end
		else
		begin
			bat_s1_ff <= BATTERY_SENSE_IN;
			bat_s2_ff <= bat_s1_ff;
			dck_s1_ff <= DECODER_CLOCK_IN;
			dck_s2_ff <= dck_s1_ff;
			dck_s3_ff <= dck_s2_ff;
		end
	end

	assign dck_tick = dck_s2_ff & ~dck_s3_ff;

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// data is prepared in setup so the access phase completes without wait
	assign setup       = PSEL_IN & ~PENABLE_IN;
	assign access_done = PSEL_IN & PENABLE_IN & PREADY_OUT;
	assign addr_ok     = is_reg(PADDR_IN);
	assign rd_status   = access_done & ~PWRITE_IN & (PADDR_IN == rf_frontend_pkg::STATUS_OFS);
	assign wr_hit      = access_done & PWRITE_IN;

	always_comb
	begin
		rd_word = 32'h00000000;
		case (PADDR_IN)
			rf_frontend_pkg::CTRL_OFS:
			begin
				rd_word[rf_frontend_pkg::CTRL_MON_RXE_BIT] = mon_rxe_ff;
				rd_word[rf_frontend_pkg::CTRL_CONT_EN_BIT] = cont_en_ff;
				rd_word[rf_frontend_pkg::CTRL_DEC_ON_BIT]  = dec_on_ff;
			end
			rf_frontend_pkg::STATUS_OFS:
			begin
				rd_word[rf_frontend_pkg::STAT_MON_BIT]     = mon_bit;
				rd_word[rf_frontend_pkg::STAT_INT_BIT]     = INT_OUT;
				rd_word[rf_frontend_pkg::STAT_RXE_BIT]     = RECEIVER_ENABLE_OUT;
				rd_word[rf_frontend_pkg::STAT_ROE_BIT]     = OSCILLATOR_ENABLE_OUT;
				rd_word[rf_frontend_pkg::STAT_BUSY_BIT]    = synth_busy;
				rd_word[rf_frontend_pkg::STAT_RX_SET_BIT]  = RX_SETTLED_OUT;
				rd_word[rf_frontend_pkg::STAT_OSC_SET_BIT] = OSC_SETTLED_OUT;
				rd_word[rf_frontend_pkg::STAT_BAT_BIT]     = bat_ff;
			end
			rf_frontend_pkg::CONFIG_OFS:
			begin
				rd_word[6:0] = {osc_est_ff, rx_est_ff, rate_ff, synth_sel_ff};
			end
			rf_frontend_pkg::BLOCK1_OFS:
			begin
				rd_word[23:0] = block1_ff;
			end
			rf_frontend_pkg::BLOCK2_OFS:
			begin
				rd_word[23:0] = block2_ff;
			end
			default:
			begin
				rd_word = 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			PREADY_OUT  <= 1'b0;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT  <= 32'h00000000;
		end
		else
		begin
			PREADY_OUT  <= setup;
			PSLVERR_OUT <= setup & ~addr_ok;
			PRDATA_OUT  <= setup ? rd_word : 32'h00000000;
		end
	end

	// ----------------------------------------
	// control and configuration registers
	// ----------------------------------------
	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			{dec_on_ff, cont_en_ff, mon_rxe_ff} <= rf_frontend_pkg::CTRL_RESET;
			{osc_est_ff, rx_est_ff, rate_ff, synth_sel_ff} <= rf_frontend_pkg::CFG_RESET;
			block1_ff <= 24'h000000;
			block2_ff <= 24'h000000;
		end
		else if (wr_hit)
		begin
			case (PADDR_IN)
				rf_frontend_pkg::CTRL_OFS:
				begin
					mon_rxe_ff <= PWDATA_IN[rf_frontend_pkg::CTRL_MON_RXE_BIT];
					cont_en_ff <= PWDATA_IN[rf_frontend_pkg::CTRL_CONT_EN_BIT];
					dec_on_ff  <= PWDATA_IN[rf_frontend_pkg::CTRL_DEC_ON_BIT];
				end
				rf_frontend_pkg::CONFIG_OFS:
				begin
					{osc_est_ff, rx_est_ff, rate_ff, synth_sel_ff} <= PWDATA_IN[6:0];
				end
				rf_frontend_pkg::BLOCK1_OFS:
				begin
					block1_ff <= PWDATA_IN[23:0];
				end
				rf_frontend_pkg::BLOCK2_OFS:
				begin
					block2_ff <= PWDATA_IN[23:0];
				end
				default:
				begin
					block1_ff <= block1_ff;
				end
			endcase
		end
	end

	// ----------------------------------------
	// receiver and oscillator enables
	// ----------------------------------------
	// the oscillator also stays on while the synthesizer is loaded
	assign nxt_rxe  = cont_en_ff | (dec_on_ff & RX_REQUEST_IN);
	assign nxt_roe  = cont_en_ff | (dec_on_ff & OSC_REQUEST_IN) | synth_busy;
	assign rxe_fall = RECEIVER_ENABLE_OUT & ~nxt_rxe;

	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			RECEIVER_ENABLE_OUT   <= 1'b0;
			OSCILLATOR_ENABLE_OUT <= 1'b0;
		end
		else
		begin
			RECEIVER_ENABLE_OUT   <= nxt_rxe;
			OSCILLATOR_ENABLE_OUT <= nxt_roe;
		end
	end

	// settle counters restart each time an enable rises
	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			rx_cnt_ff      <= 32'h00000000;
			osc_cnt_ff     <= 32'h00000000;
			RX_SETTLED_OUT  <= 1'b0;
			OSC_SETTLED_OUT <= 1'b0;
		end
		else
		begin
			if (!RECEIVER_ENABLE_OUT)
			begin
				rx_cnt_ff      <= est_cycles(rx_est_ff, 1'b0);
				RX_SETTLED_OUT <= 1'b0;
			end
			else if (rx_cnt_ff > 32'h00000001)
			begin
				rx_cnt_ff <= rx_cnt_ff - 32'h00000001;
			end
			else
			begin
				RX_SETTLED_OUT <= 1'b1;
			end
			if (!OSCILLATOR_ENABLE_OUT)
			begin
				osc_cnt_ff      <= est_cycles(osc_est_ff, 1'b1);
				OSC_SETTLED_OUT <= 1'b0;
			end
			else if (osc_cnt_ff > 32'h00000001)
			begin
				osc_cnt_ff <= osc_cnt_ff - 32'h00000001;
			end
			else
			begin
				OSC_SETTLED_OUT <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// battery sample, monitor bit, interrupt
	// ----------------------------------------
	assign mon_bit = mon_rxe_ff ? RECEIVER_ENABLE_OUT : bat_ff;

	// a sample only changes when the receiver turns off, so the battery
	// interrupt is naturally deferred; select changes raise nothing
	assign irq_set = (mon_rxe_ff & (nxt_rxe != RECEIVER_ENABLE_OUT)) |
		(~mon_rxe_ff & rxe_fall & (bat_s2_ff != bat_ff));

	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			bat_ff <= 1'b0;
		end
		else if (rxe_fall)
		begin
			bat_ff <= bat_s2_ff;
		end
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			INT_OUT <= 1'b0;
		end
		else if (irq_set)
		begin
			INT_OUT <= 1'b1;
		end
		else if (rd_status)
		begin
			INT_OUT <= 1'b0;
		end
	end

	// ----------------------------------------
	// synthesizer load
	// ----------------------------------------
	always_comb
	begin
		case (rate_ff)
			rf_frontend_pkg::RATE_512:  pause_len = rf_frontend_pkg::PAUSE_512;
			rf_frontend_pkg::RATE_1200: pause_len = rf_frontend_pkg::PAUSE_1200;
			default:                    pause_len = rf_frontend_pkg::PAUSE_2400;
		endcase
	end

	// a second off-to-on while a load runs is not queued
	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			dec_on_prev_ff <= 1'b0;
			start_ff       <= 1'b0;
			first_ff       <= 1'b1;
		end
		else
		begin
			dec_on_prev_ff <= dec_on_ff;
			start_ff       <= dec_on_ff & ~dec_on_prev_ff & synth_sel_ff;
			first_ff       <= 1'b0;
		end
	end

	synth_loader u_synth_loader
	(
		.clk_in    (CLK_IN),
		.arst_n_in (ARST_N_IN),
		.tick_in   (dck_tick),
		.start_in  (start_ff),
		.block1_in (block1_ff),
		.block2_in (block2_ff),
		.pause_in  (pause_len),
		.sd_out    (SYNTH_SERIAL_DATA_OUT),
		.sc_out    (SYNTH_SERIAL_CLOCK_OUT),
		.le_out    (SYNTH_LATCH_STROBE_OUT),
		.busy_out  (synth_busy)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	cont_both_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		cont_en_ff |=> RECEIVER_ENABLE_OUT && OSCILLATOR_ENABLE_OUT)
		else $error("continuous enable did not force both outputs");

	cont_clear_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		$fell(cont_en_ff) |-> $past(wr_hit) && $past(PADDR_IN) == rf_frontend_pkg::CTRL_OFS)
		else $error("continuous enable cleared without a control write");

	rxe_irq_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		$past(mon_rxe_ff) && $changed(RECEIVER_ENABLE_OUT) |-> INT_OUT)
		else $error("receiver enable change gave no interrupt");

	bat_sample_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		$fell(RECEIVER_ENABLE_OUT) |-> bat_ff == $past(bat_s2_ff))
		else $error("battery not sampled at receiver disable");

	bat_irq_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		$changed(bat_ff) && !$past(mon_rxe_ff) |-> INT_OUT && !RECEIVER_ENABLE_OUT)
		else $error("battery change gave no interrupt");

	mon_read_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		$past(setup) && $past(PADDR_IN) == rf_frontend_pkg::STATUS_OFS && $past(mon_rxe_ff)
		|-> PRDATA_OUT[rf_frontend_pkg::STAT_MON_BIT] == $past(RECEIVER_ENABLE_OUT))
		else $error("status bit does not show receiver enable");

	bat_reset_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		first_ff |-> !bat_ff)
		else $error("battery indicator not zero after reset");

	rx_settle_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		$rose(RX_SETTLED_OUT) |-> $past(rx_cnt_ff) == 32'h00000001 && $past(RECEIVER_ENABLE_OUT))
		else $error("receiver settled before establishment time");

	synth_start_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		$rose(dec_on_ff) && synth_sel_ff && !synth_busy |-> ##2 synth_busy)
		else $error("synthesizer load did not start on switch-on");

endmodule
`default_nettype wire

// >>> src/rf_frontend_pkg.sv
// constants for the rf front-end control block
package rf_frontend_pkg;

	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned MS_PER_S      = 1000;
	localparam int unsigned CLKS_PER_MS   = CLK_HZ / MS_PER_S;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS       = 8'h00;
	localparam logic [7:0] STATUS_OFS     = 8'h04;
	localparam logic [7:0] CONFIG_OFS     = 8'h08;
	localparam logic [7:0] BLOCK1_OFS     = 8'h0C;
	localparam logic [7:0] BLOCK2_OFS     = 8'h10;

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	localparam int unsigned CTRL_MON_RXE_BIT  = 2;
	localparam int unsigned CTRL_CONT_EN_BIT  = 3;
	localparam int unsigned CTRL_DEC_ON_BIT   = 4;
	localparam logic [2:0]  CTRL_RESET        = 3'h0;

	// ----------------------------------------
	// configuration fields
	// ----------------------------------------
	localparam int unsigned CFG_SYNTH_SEL_BIT = 0;
	localparam int unsigned CFG_RATE_LSB      = 1;
	localparam int unsigned CFG_RX_EST_LSB    = 3;
	localparam int unsigned CFG_OSC_EST_LSB   = 5;
	localparam logic [6:0]  CFG_RESET         = 7'h00;

	// ----------------------------------------
	// status fields
	// ----------------------------------------
	localparam int unsigned STAT_MON_BIT      = 6;
	localparam int unsigned STAT_INT_BIT      = 0;
	localparam int unsigned STAT_RXE_BIT      = 1;
	localparam int unsigned STAT_ROE_BIT      = 2;
	localparam int unsigned STAT_BUSY_BIT     = 3;
	localparam int unsigned STAT_RX_SET_BIT   = 4;
	localparam int unsigned STAT_OSC_SET_BIT  = 5;
	localparam int unsigned STAT_BAT_BIT      = 7;

	// ----------------------------------------
	// establishment times in ms, per select code
	// ----------------------------------------
	localparam int unsigned RX_EST_MS_0  = 5;
	localparam int unsigned RX_EST_MS_1  = 10;
	localparam int unsigned RX_EST_MS_2  = 15;
	localparam int unsigned RX_EST_MS_3  = 30;
	localparam int unsigned OSC_EST_MS_0 = 20;
	localparam int unsigned OSC_EST_MS_1 = 30;
	localparam int unsigned OSC_EST_MS_2 = 40;
	localparam int unsigned OSC_EST_MS_3 = 50;

	// ----------------------------------------
	// synthesizer link
	// ----------------------------------------
	localparam int unsigned SYNTH_BITS      = 24;
	localparam int unsigned PAUSE_BIT_IDX   = 12;
	localparam logic [1:0]  RATE_512        = 2'h0;
	localparam logic [1:0]  RATE_1200       = 2'h1;
	localparam logic [6:0]  PAUSE_512       = 7'h77;
	localparam logic [6:0]  PAUSE_1200      = 7'h21;
	localparam logic [6:0]  PAUSE_2400      = 7'h01;

endpackage

// >>> src/synth_loader.sv
// three-wire serial loader for the external frequency synthesizer
`timescale 1ns/100ps
`default_nettype none

module synth_loader
(
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	input  wire logic        tick_in,
	input  wire logic        start_in,
	input  wire logic [23:0] block1_in,
	input  wire logic [23:0] block2_in,
	input  wire logic [6:0]  pause_in,
	output logic             sd_out,
	output logic             sc_out,
	output logic             le_out,
	output logic             busy_out
);

	typedef enum logic [2:0] {S_IDLE, S_LOW, S_PAUSE, S_HIGH, S_LATCH, S_GAP} load_state_type;

	load_state_type state_ff;
	logic [23:0]    shift_ff;
	logic [23:0]    blk2_ff;
	logic [4:0]     idx_ff;
	logic [6:0]     cnt_ff;
	logic           second_ff;

	// ----------------------------------------
	// serial sequencer
	// ----------------------------------------
	// one decoder clock per serial clock half period
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_ff  <= S_IDLE;
			shift_ff  <= 24'h000000;
			blk2_ff   <= 24'h000000;
			idx_ff    <= 5'h00;
			cnt_ff    <= 7'h00;
			second_ff <= 1'b0;
			sd_out    <= 1'b0;
			sc_out    <= 1'b0;
			le_out    <= 1'b0;
			busy_out  <= 1'b0;
		end
		else
		begin
			case (state_ff)
				S_IDLE:
				begin
					if (start_in)
					begin
						shift_ff  <= block1_in;
						blk2_ff   <= block2_in;
						sd_out    <= block1_in[23];
						idx_ff    <= 5'h00;
						second_ff <= 1'b0;
						busy_out  <= 1'b1;
						state_ff  <= S_LOW;
					end
				end
				S_LOW:
				begin
					if (tick_in)
					begin
						if (idx_ff == 5'(rf_frontend_pkg::PAUSE_BIT_IDX))
						begin
							cnt_ff   <= pause_in;
							state_ff <= S_PAUSE;
						end
						else
						begin
							sc_out   <= 1'b1;
							state_ff <= S_HIGH;
						end
					end
				end
				S_PAUSE:
				begin
					if (tick_in)
					begin
						if (cnt_ff <= 7'h01)
						begin
							sc_out   <= 1'b1;
							state_ff <= S_HIGH;
						end
						else
						begin
							cnt_ff <= cnt_ff - 7'h01;
						end
					end
				end
				S_HIGH:
				begin
					if (tick_in)
					begin
						sc_out <= 1'b0;
						if (idx_ff == 5'(rf_frontend_pkg::SYNTH_BITS - 1))
						begin
							le_out   <= 1'b1;
							state_ff <= S_LATCH;
						end
						else
						begin
							shift_ff <= {shift_ff[22:0], 1'b0};
							sd_out   <= shift_ff[22];
							idx_ff   <= idx_ff + 5'h01;
							state_ff <= S_LOW;
						end
					end
				end
				S_LATCH:
				begin
					if (tick_in)
					begin
						le_out <= 1'b0;
						if (!second_ff)
						begin
							cnt_ff   <= pause_in;
							state_ff <= S_GAP;
						end
						else
						begin
							busy_out <= 1'b0;
							state_ff <= S_IDLE;
						end
					end
				end
				S_GAP:
				begin
					if (tick_in)
					begin
						if (cnt_ff <= 7'h01)
						begin
							second_ff <= 1'b1;
							shift_ff  <= blk2_ff;
							sd_out    <= blk2_ff[23];
							idx_ff    <= 5'h00;
							state_ff  <= S_LOW;
						end
						else
						begin
							cnt_ff <= cnt_ff - 7'h01;
						end
					end
				end
				default:
				begin
					state_ff <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sd_on_low_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$changed(sd_out) |-> !sc_out)
		else $error("serial data changed while serial clock high");

	latch_last_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(le_out) |-> $past(idx_ff) == 5'h17 && !sc_out)
		else $error("latch pulse not after last bit");

	pause_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		state_ff == S_PAUSE |-> !sc_out && idx_ff == 5'h0C)
		else $error("pause outside low phase of bit 13");

endmodule
`default_nettype wire

// >>> verif/synth_model.sv
// behavioural synthesizer on the three-wire load link
`timescale 1ns/100ps
`default_nettype none
module synth_model
(
	input  wire logic        clk_in,
	input  wire logic        sd_in,
	input  wire logic        sc_in,
	input  wire logic        le_in,
	output logic      [23:0] first_out = 24'h0,
	output logic      [23:0] second_out = 24'h0,
	output logic      [7:0]  loads_out = 8'h00,
	output logic      [11:0] low_out = 12'h000,
	output logic      [11:0] gap_out = 12'h000,
	output logic             skew_out = 1'b0
);
	logic [23:0] shift_ff = 24'h0;
	logic [11:0] low_ff   = 12'h000;
	logic [4:0]  bits_ff  = 5'h00;
	logic        sc_ff    = 1'b0;
	logic        sd_ff    = 1'b0;
	logic        le_ff    = 1'b0;
	always @(posedge clk_in)
	begin
		sc_ff <= sc_in;
		sd_ff <= sd_in;
		le_ff <= le_in;
		low_ff <= sc_in ? 12'h000 : low_ff + 12'h001;
		if (sc_in && !sc_ff)
		begin
			shift_ff <= {shift_ff[22:0], sd_in};
			bits_ff <= bits_ff + 5'h01;
			if (bits_ff == 5'h0C)
				low_out <= low_ff;
			// low time from the first block's last bit to the second block's first bit
			if (bits_ff == 5'h00 && loads_out[0])
				gap_out <= low_ff;
		end
		if (sc_in && sc_ff && sd_in != sd_ff)
			skew_out <= 1'b1;
		// only the trailing 24 bits survive, leading ones shift out
		if (le_in && !le_ff)
		begin
			bits_ff <= 5'h00;
			loads_out <= loads_out + 8'h01;
			if (loads_out[0])
				second_out <= shift_ff;
			else
				first_out <= shift_ff;
		end
	end
endmodule
`default_nettype wire

// >>> verif/rf_frontend_control_bench.sv
// self-checking bench for the rf front-end control block
`timescale 1ns/100ps
`default_nettype none
module rf_frontend_control_bench;
	logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, b1, b2, cfg;
	logic        pready, pslverr, err, receiver_enable_out, oscillator_enable_out, rx_set, osc_set, irq, sd, sc, le, skew;
	logic        rx_req = 0, osc_req = 0, battery_sense_in = 0, dclk = 0;
	logic [23:0] w1, w2;
	logic [7:0]  loads;
	logic [11:0] low, gap;
	int          miscompares = 0;
	int          comparisons = 0;
	always #5 clk = ~clk;
	always #80 dclk = ~dclk;
	rf_frontend_control #(.CLKS_PER_MS(10)) dut_u
	(
		.CLK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.RX_REQUEST_IN(rx_req), .OSC_REQUEST_IN(osc_req), .BATTERY_SENSE_IN(battery_sense_in), .DECODER_CLOCK_IN(dclk),
		.RECEIVER_ENABLE_OUT(receiver_enable_out), .OSCILLATOR_ENABLE_OUT(oscillator_enable_out), .RX_SETTLED_OUT(rx_set),
		.OSC_SETTLED_OUT(osc_set), .INT_OUT(irq), .SYNTH_SERIAL_DATA_OUT(sd),
		.SYNTH_SERIAL_CLOCK_OUT(sc), .SYNTH_LATCH_STROBE_OUT(le)
	);
	synth_model model_u
	(
		.clk_in(clk), .sd_in(sd), .sc_in(sc), .le_in(le), .first_out(w1), .second_out(w2),
		.loads_out(loads), .low_out(low), .gap_out(gap), .skew_out(skew)
	);
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task results;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// request held until pready is seen at a rising edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		check("pready", pready, 1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wait_loads(input int n);
		int k;
		k = 0;
		while (loads !== n[7:0] && k < 20000)
		begin
			@(posedge clk);
			k++;
		end
		check("loads", loads, n[7:0]);
	endtask
	function automatic int pv(input int r);
		return r == 0 ? 119 : r == 1 ? 33 : 1;
	endfunction
	// establishment time in cycles at 10 cycles per ms
	function automatic int est(input logic [1:0] c, input logic o);
		return 10 * (o ? 20 + 10 * c : (c == 2'h3 ? 30 : 5 + 5 * c));
	endfunction
	initial
	begin
		#500000;
		miscompares++;
		results;
	end
	initial
	begin
		void'($urandom(39338));
		tick(2);
		arst_n <= 1;
		apb(0, rf_frontend_pkg::STATUS_OFS, 0);
		check("status", rd, 0);
		apb(0, 8'h14, 0);
		check("unmapped", {rd[30:0], err}, 1);
		cfg = $urandom;
		apb(1, rf_frontend_pkg::CONFIG_OFS, {25'h0, cfg[3:0], 3'h0});
		apb(1, rf_frontend_pkg::CTRL_OFS, 32'h10);
		osc_req <= 1;
		tick(3);
		check("enables", {receiver_enable_out, oscillator_enable_out}, 2'h1);
		osc_req <= 0;
		tick(3);
		rx_req <= 1;
		tick(est(cfg[1:0], 0) + 1);
		check("rx_settle", {receiver_enable_out, oscillator_enable_out, rx_set}, 3'h4);
		tick(1);
		check("rx_settle", {receiver_enable_out, rx_set}, 2'h3);
		osc_req <= 1;
		tick(est(cfg[3:2], 1) + 1);
		check("osc_settle", {oscillator_enable_out, osc_set}, 2'h2);
		tick(1);
		check("osc_settle", {oscillator_enable_out, osc_set}, 2'h3);
		osc_req <= 0;
		for (int i = 1; i >= 0; i--)
		begin
			battery_sense_in <= i[0];
			tick(5);
			check("irq", irq, 0);
			rx_req <= 0;
			tick(5);
			check("irq", irq, 1);
			apb(0, rf_frontend_pkg::STATUS_OFS, 0);
			check("monitor", rd[7:6], {i[0], i[0]});
			rx_req <= 1;
			tick(5);
		end
		apb(1, rf_frontend_pkg::CTRL_OFS, 32'h14);
		for (int v = 0; v < 2; v++)
		begin
			rx_req <= v[0];
			tick(3);
			check("irq", irq, 1);
			apb(0, rf_frontend_pkg::STATUS_OFS, 0);
			check("monitor", rd[6], v[0]);
		end
		apb(1, rf_frontend_pkg::CTRL_OFS, 32'h08);
		rx_req <= 0;
		tick(3);
		check("forced", {receiver_enable_out, oscillator_enable_out}, 2'h3);
		apb(1, rf_frontend_pkg::CTRL_OFS, 0);
		tick(3);
		check("forced", {receiver_enable_out, oscillator_enable_out}, 2'h0);
		for (int r = 0; r < 3; r++)
		begin
			// fresh blocks each load so a missed load cannot pass on stale words
			b1 = (r == 0) ? 32'h00800001 : $urandom;
			b2 = $urandom;
			apb(1, rf_frontend_pkg::BLOCK1_OFS, b1);
			apb(1, rf_frontend_pkg::BLOCK2_OFS, b2);
			apb(1, rf_frontend_pkg::CONFIG_OFS, 2 * r + 1);
			apb(1, rf_frontend_pkg::CTRL_OFS, 32'h10);
			wait_loads(2 * r + 1);
			check("roe", oscillator_enable_out, 1);
			wait_loads(2 * r + 2);
			check("block1", w1, b1[23:0]);
			check("block2", w2, b2[23:0]);
			check("pause", low, 16 * (1 + pv(r)));
			check("gap", gap, 16 * (2 + pv(r)));
			apb(1, rf_frontend_pkg::CTRL_OFS, 0);
			tick(40);
			check("roe", oscillator_enable_out, 0);
		end
		check("skew", skew, 0);
		results;
	end
endmodule
`default_nettype wire
